/* core/ossp_pkg.sv */
// Constants shared by the optical sensor serial port and its dwell timer.
// Assumes a single 100 MHz core clock; all times are turned into cycle counts here.
// How it works
// RULE1 - Port only answers transfers the host starts.
// RULE2 - Deselected: ignore clock, data; release MISO.
// RULE3 - Port wakes only after chip select falls.
// RULE4 - Chip select rising aborts, resets port logic.
// RULE5 - Host keeps normal delays after an abort.
// RULE6 - Host frames every transaction with chip select.
// RULE7 - Burst locks port until chip select rises.
// RULE8 - No motion steps run, tier1, tier2, tier3.
// RULE9 - Default dwells: under 1s, 10s, 600s.
// RULE10 - Default wake response: 20, 100, 500 ms.
// RULE11 - Registers 0x0e..0x13 program periods and dwells.
// RULE12 - Motion raises movement interrupt toward host.
// RULE13 - Interrupt selectable level/edge and polarity.
// RULE14 - Level mode follows move flag with unread data.
// RULE15 - All data read: zero displacement, clear flag.
// RULE16 - Edge mode: 380 ns pulse on rest wake.
// RULE17 - Move flag set when displacement is ready.
// RULE18 - Twelve-bit mode adds upper nibbles register.
// RULE19 - Write: address byte MSB one, then data.
// RULE20 - MOSI sampled on rising serial clock.
// RULE21 - Host alone drives the serial clock.
// RULE22 - Read: MSB zero; data changes on falling clock.
// RULE23 - Host waits 4 us before read data.
// RULE24 - Motion in rest returns to run, restarts dwell.
// RULE25 - Serial inputs synchronised; edges found internally.
package ossp_pkg;

	localparam int CLK_PERIOD_NS = 10;

	// Register addresses on the serial port.
	localparam logic [6:0] ADDR_MOVE_STAT  = 7'h02;
	localparam logic [6:0] ADDR_DISP_X     = 7'h03;
	localparam logic [6:0] ADDR_DISP_Y     = 7'h04;
	localparam logic [6:0] ADDR_DISP_UPPER = 7'h0C;
	localparam logic [6:0] ADDR_CFG_FIRST  = 7'h0E;
	localparam logic [6:0] ADDR_CFG_LAST   = 7'h13;
	localparam logic [6:0] ADDR_BURST      = 7'h63;
	localparam int         CFG_COUNT       = 6;

	// Field position of move_flag inside the status register.
	localparam int MOVE_FLAG_BIT = 7;

	// Reset values of the six tier configuration registers, in address order.
	localparam logic [7:0] CFG_RESET [CFG_COUNT] = '{8'h08, 8'h01, 8'h1F, 8'h09, 8'h2F, 8'h31};
	localparam int CFG_RUN_DWELL = 0;
	localparam int CFG_T1_PERIOD = 1;
	localparam int CFG_T1_DWELL  = 2;
	localparam int CFG_T2_PERIOD = 3;
	localparam int CFG_T2_DWELL  = 4;
	localparam int CFG_T3_PERIOD = 5;

	// Base time tick; periods are (value + 1) ticks.
	localparam int TICK_MS     = 10;
	localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;

	// Dwell units in base ticks: 100 ms, 320 ms and 12.8 s per count.
	localparam logic [19:0] DWELL_UNIT_RUN = 20'h0000A;
	localparam logic [19:0] DWELL_UNIT_T1  = 20'h00020;
	localparam logic [19:0] DWELL_UNIT_T2  = 20'h00500;

	// Edge-mode interrupt pulse, rounded down to whole cycles.
	localparam int         IRQ_PULSE_NS  = 380;
	localparam logic [5:0] IRQ_PULSE_CYC = 6'(IRQ_PULSE_NS / CLK_PERIOD_NS);

	typedef enum logic [3:0] {
		TIER_RUN = 4'b0001,
		TIER_1   = 4'b0010,
		TIER_2   = 4'b0100,
		TIER_3   = 4'b1000
	} ossp_tier_t;

	typedef enum logic [3:0] {
		PH_ADDR  = 4'b0001,
		PH_WDATA = 4'b0010,
		PH_RDATA = 4'b0100,
		PH_BURST = 4'b1000
	} ossp_phase_t;

endpackage

/* core/ossp_serial_port.sv */
// Four-wire serial slave, tier power management and movement interrupt of the motion sensor.
// Assumes sclk, mosi and chip_sel_n come from an external master in a foreign clock domain,
// and that motion_valid with its deltas comes from the imaging core on mclk.
`timescale 1ns/1ps
module ossp_serial_port
	import ossp_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic        sclk,
	input  wire logic        mosi,
	input  wire logic        chip_sel_n,
	output logic             miso,
	output logic             miso_oe,
	input  wire logic        motion_valid,
	input  wire logic [11:0] motion_dx,
	input  wire logic [11:0] motion_dy,
	input  wire logic        report_12bit,
	input  wire logic        irq_edge_mode,
	input  wire logic        irq_active_high,
	output logic             movement_irq,
	output logic [3:0]       power_tier,
	output logic             move_flag
);

	// Synchroniser stages; stage one feeds only stage two.
	// The third clock stage only finds edges; it never feeds a data path.
	logic cs_s1_q, cs_s2_q;
	logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
	logic mosi_s1_q, mosi_s2_q;

	// Serial engine state.
	// The bit counter wraps at eight, so every byte boundary falls out of it.
	ossp_phase_t phase_q;
	logic [2:0]  bit_cnt_q;
	logic [7:0]  shin_q;
	logic [6:0]  waddr_q;
	logic [7:0]  shout_q;
	logic        miso_q;
	logic [2:0]  burst_idx_q;

	// Register file and motion data.
	// Displacement is kept at twelve bits whatever the reporting width.
	logic [7:0]  cfg_q [CFG_COUNT];
	logic [11:0] disp_x_q, disp_y_q;
	logic        move_flag_q;
	logic        seen_x_q, seen_y_q, seen_u_q;

	// Power management and interrupt.
	ossp_tier_t  tier_q;
	logic        pending_q;
	logic [5:0]  pulse_cnt_q;
	logic        irq_q;
	logic [23:0] tick_cnt_q;
	logic        tick_q;

	// All three serial inputs cross two flops before anything looks at them.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cs_s1_q   <= 1'b1;
			cs_s2_q   <= 1'b1;
			sclk_s1_q <= 1'b1;
			sclk_s2_q <= 1'b1;
			sclk_s3_q <= 1'b1;
			mosi_s1_q <= 1'b0;
			mosi_s2_q <= 1'b0;
		end else if (clk_en) begin
			cs_s1_q   <= chip_sel_n; // RULE25
			cs_s2_q   <= cs_s1_q;
			sclk_s1_q <= sclk; // RULE25
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			mosi_s1_q <= mosi; // RULE25
			mosi_s2_q <= mosi_s1_q;
		end
	end

	// Edges are only honoured while selected, so stray clocks on a shared bus do nothing.
	wire       port_on    = ~cs_s2_q; // RULE2 RULE3
	wire       sclk_rise  = port_on & sclk_s2_q & ~sclk_s3_q; // RULE25 RULE20
	wire       sclk_fall  = port_on & ~sclk_s2_q & sclk_s3_q; // RULE25 RULE22
	wire [7:0] shin_next  = {shin_q[6:0], mosi_s2_q};
	wire       byte_done  = sclk_rise & (bit_cnt_q == 3'h7);
	wire [6:0] rx_addr    = shin_next[6:0];

	// Byte-level decode of what just completed.
	wire addr_done  = byte_done & (phase_q == PH_ADDR);
	wire is_write   = addr_done & shin_next[7]; // RULE19
	wire is_read    = addr_done & ~shin_next[7]; // RULE22
	wire start_bst  = is_read & (rx_addr == ADDR_BURST);
	wire wr_take    = byte_done & (phase_q == PH_WDATA); // RULE19
	wire bst_next   = byte_done & (phase_q == PH_BURST);
	wire rd_phase   = (phase_q == PH_RDATA) | (phase_q == PH_BURST);

	// Register read selection; unmapped addresses read zero.
	wire [7:0] upper_byte = {disp_x_q[11:8], disp_y_q[11:8]}; // RULE18
	wire       rd_cfg     = (rx_addr >= ADDR_CFG_FIRST) & (rx_addr <= ADDR_CFG_LAST);
	wire [2:0] rd_cfg_idx = 3'(rx_addr - ADDR_CFG_FIRST);
	wire [7:0] status_byte = 8'(move_flag_q) << MOVE_FLAG_BIT;
	wire [7:0] rd_data =
		(rx_addr == ADDR_MOVE_STAT)  ? status_byte :
		(rx_addr == ADDR_DISP_X)     ? disp_x_q[7:0] :
		(rx_addr == ADDR_DISP_Y)     ? disp_y_q[7:0] :
		(rx_addr == ADDR_DISP_UPPER) ? upper_byte :
		rd_cfg                       ? cfg_q[rd_cfg_idx] : 8'h00;

	// Burst streams x, y, then the upper nibbles when twelve-bit, then zeros.
	wire [2:0] bst_idx  = start_bst ? 3'h0 : burst_idx_q;
	wire [7:0] bst_data =
		(bst_idx == 3'h0) ? disp_x_q[7:0] :
		(bst_idx == 3'h1) ? disp_y_q[7:0] :
		((bst_idx == 3'h2) && report_12bit) ? upper_byte : 8'h00; // RULE18
	wire       bst_load = start_bst | bst_next;

	// Which displacement bytes the host has now taken.
	wire take_x = (is_read & (rx_addr == ADDR_DISP_X)) | (bst_load & (bst_idx == 3'h0));
	wire take_y = (is_read & (rx_addr == ADDR_DISP_Y)) | (bst_load & (bst_idx == 3'h1));
	wire take_u = (is_read & (rx_addr == ADDR_DISP_UPPER))
		| (bst_load & (bst_idx == 3'h2) & report_12bit);

	// Phase sequencing; deselect drops any half-done transaction.
	// Burst keeps the phase locked until deselect, so no byte inside it is decoded.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			phase_q <= PH_ADDR;
		end else if (clk_en) begin
			if (!port_on) begin
				phase_q <= PH_ADDR; // RULE4
			end else if (byte_done) begin
				unique case (phase_q)
					PH_ADDR: begin
						phase_q <= is_write ? PH_WDATA : (start_bst ? PH_BURST : PH_RDATA);
					end
					PH_WDATA: phase_q <= PH_ADDR;
					PH_RDATA: phase_q <= PH_ADDR;
					PH_BURST: phase_q <= PH_BURST; // RULE7
				endcase
			end
		end
	end

	// Bit counter and input shifter move only on qualified rising edges.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt_q <= 3'h0;
			shin_q    <= 8'h00;
			waddr_q   <= 7'h00;
		end else if (clk_en) begin
			if (!port_on) begin
				bit_cnt_q <= 3'h0; // RULE4
			end else if (sclk_rise) begin
				bit_cnt_q <= bit_cnt_q + 3'h1;
				shin_q    <= shin_next; // RULE20
				if (is_write) begin
					waddr_q <= rx_addr;
				end
			end
		end
	end

	// Output shifter: loaded when the address completes, shifted on falling edges.
	// The host must leave the address-to-data gap so the byte is ready in time.
	// Deselect clears the output bit so a later select never shows stale data.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			shout_q     <= 8'h00;
			miso_q      <= 1'b0;
			burst_idx_q <= 3'h0;
		end else if (clk_en) begin
			if (!port_on) begin
				burst_idx_q <= 3'h0; // RULE4
				miso_q      <= 1'b0;
			end else if (bst_load) begin
				shout_q     <= bst_data;
				burst_idx_q <= (bst_idx == 3'h7) ? 3'h7 : bst_idx + 3'h1;
			end else if (is_read) begin
				shout_q <= rd_data; // RULE22 RULE23
			end else if (sclk_fall && rd_phase) begin
				miso_q  <= shout_q[7]; // RULE22
				shout_q <= {shout_q[6:0], 1'b0};
			end
		end
	end

	// Pin only driven while selected; the bit itself comes straight from a flop.
	assign miso    = miso_q;
	assign miso_oe = port_on; // RULE2 RULE1

	// Tier configuration registers; writes elsewhere are dropped.
	// A write takes effect one clock after its last data bit is seen.
	wire       wr_cfg     = wr_take & (waddr_q >= ADDR_CFG_FIRST) & (waddr_q <= ADDR_CFG_LAST);
	wire [2:0] wr_cfg_idx = 3'(waddr_q - ADDR_CFG_FIRST);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < CFG_COUNT; i++) begin
				cfg_q[i] <= CFG_RESET[i]; // RULE9 RULE10
			end
		end else if (clk_en && wr_cfg) begin
			cfg_q[wr_cfg_idx] <= shin_next; // RULE11
		end
	end

	// Base tick for every tier timer; long, so a bench may shorten it.
	// Every tier measures time in these ticks, so one counter serves them all.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_q <= 24'h000000;
			tick_q     <= 1'b0;
		end else if (clk_en) begin
			tick_q     <= (tick_cnt_q == 24'(TICK_LEN - 1));
			tick_cnt_q <= (tick_cnt_q == 24'(TICK_LEN - 1)) ? 24'h000000 : tick_cnt_q + 24'h000001;
		end
	end

	// Period and dwell limits for the current tier.
	wire        in_run  = (tier_q == TIER_RUN);
	wire [19:0] per_lim =
		(tier_q == TIER_1) ? 20'(cfg_q[CFG_T1_PERIOD]) + 20'h00001 :
		(tier_q == TIER_2) ? 20'(cfg_q[CFG_T2_PERIOD]) + 20'h00001 :
		20'(cfg_q[CFG_T3_PERIOD]) + 20'h00001; // RULE10 RULE11
	wire [19:0] dwell_lim =
		in_run             ? 20'(20'(cfg_q[CFG_RUN_DWELL]) * DWELL_UNIT_RUN) :
		(tier_q == TIER_1) ? 20'(20'(cfg_q[CFG_T1_DWELL]) * DWELL_UNIT_T1) :
		20'(20'(cfg_q[CFG_T2_DWELL]) * DWELL_UNIT_T2); // RULE9 RULE11

	// In a rest tier motion is only looked at once per sampling period.
	// The period timer paces sampling in a rest tier; the dwell timer paces downshifts.
	// Both restart on a tier change, so a new tier always starts a full interval.
	logic per_done;
	logic dwell_done;
	wire  sample    = ~in_run & per_done;
	wire  accept    = in_run ? motion_valid : (sample & (pending_q | motion_valid));
	wire  wake      = accept & ~in_run; // RULE24
	wire  downshift = dwell_done & (tier_q != TIER_3) & ~accept;
	wire  tier_chg  = wake | downshift;

	ossp_tier_timer #(
		.W(20)
	) u_period (
		.mclk    (mclk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.restart (tier_chg | sample),
		.tick    (tick_q),
		.limit   (per_lim),
		.done    (per_done)
	);

	ossp_tier_timer #(
		.W(20)
	) u_dwell (
		.mclk    (mclk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.restart (tier_chg | accept), // RULE24
		.tick    (tick_q),
		.limit   (dwell_lim),
		.done    (dwell_done)
	);

	// Tier walk: deeper on quiet dwell, back to run on any accepted motion.
	// Tier three is the floor: it is only ever left through a wake.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tier_q    <= TIER_RUN;
			pending_q <= 1'b0;
		end else if (clk_en) begin
			pending_q <= ~in_run & ~sample & (pending_q | motion_valid);
			if (wake) begin
				tier_q <= TIER_RUN; // RULE24
			end else if (downshift) begin
				unique case (tier_q)
					TIER_RUN: tier_q <= TIER_1; // RULE8
					TIER_1:   tier_q <= TIER_2; // RULE8
					TIER_2:   tier_q <= TIER_3; // RULE8
					TIER_3:   tier_q <= TIER_3;
				endcase
			end
		end
	end

	// Displacement accumulates every frame; reading it all zeroes it.
	// A new frame in the clearing cycle survives, so motion is never lost.
	wire all_read = move_flag_q & seen_x_q & seen_y_q & (seen_u_q | ~report_12bit); // RULE15
	wire [11:0] base_x = all_read ? 12'h000 : disp_x_q;
	wire [11:0] base_y = all_read ? 12'h000 : disp_y_q;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			disp_x_q <= 12'h000;
			disp_y_q <= 12'h000;
		end else if (clk_en) begin
			disp_x_q <= motion_valid ? base_x + motion_dx : base_x; // RULE15
			disp_y_q <= motion_valid ? base_y + motion_dy : base_y; // RULE15
		end
	end

	// Flag set wins over clear; read marks restart with each accepted report.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			move_flag_q <= 1'b0;
			seen_x_q    <= 1'b0;
			seen_y_q    <= 1'b0;
			seen_u_q    <= 1'b0;
		end else if (clk_en) begin
			move_flag_q <= accept | (move_flag_q & ~all_read); // RULE17 RULE15
			seen_x_q    <= ~accept & ~all_read & (seen_x_q | take_x);
			seen_y_q    <= ~accept & ~all_read & (seen_y_q | take_y);
			seen_u_q    <= ~accept & ~all_read & (seen_u_q | take_u);
		end
	end

	// Interrupt pin: level follows the flag, edge gives a short pulse on rest wake.
	// Edge mode pulses only on a wake, so motion during run never pulses the pin.
	wire irq_level  = move_flag_q; // RULE14
	wire irq_pulse  = (pulse_cnt_q != 6'h00); // RULE16
	wire irq_assert = irq_edge_mode ? irq_pulse : irq_level; // RULE13 RULE12

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pulse_cnt_q <= 6'h00;
			irq_q       <= 1'b0;
		end else if (clk_en) begin
			if (wake) begin
				pulse_cnt_q <= IRQ_PULSE_CYC; // RULE16
			end else if (irq_pulse) begin
				pulse_cnt_q <= pulse_cnt_q - 6'h01;
			end
			irq_q <= irq_active_high ? irq_assert : ~irq_assert; // RULE13
		end
	end

	// Status outputs come straight from flops, so the pins never glitch.
	assign movement_irq = irq_q;
	assign power_tier   = tier_q;
	assign move_flag    = move_flag_q;

endmodule

/* core/ossp_tier_timer.sv */
// Saturating tick counter that flags when a programmed limit is reached.
// Assumes tick and restart come from logic on the same clock.
`timescale 1ns/1ps
module ossp_tier_timer
	import ossp_pkg::*;
#(
	parameter int W = 20
) (
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic         clk_en,
	input  wire logic         restart,
	input  wire logic         tick,
	input  wire logic [W-1:0] limit,
	output logic              done
);

	logic [W-1:0] cnt_q;

	// Count ticks up to the limit and hold there; restart wins over counting.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
		end else if (clk_en) begin
			if (restart) begin
				cnt_q <= '0;
			end else if (tick && (cnt_q < limit)) begin
				cnt_q <= cnt_q + W'(1);
			end
		end
	end

	// A limit that is lowered below the count still reads as reached.
	assign done = (cnt_q >= limit);

endmodule

/* tb/ossp_checker_assertions.sv */
// Checker of the serial port, interrupt pin and tier sequencing at the top module's ports.
// Assumes it is bound to ossp_serial_port and that clk_en low pauses everything.
`timescale 1ns/1ps
module ossp_checker
	import ossp_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input wire logic       mclk,
	input wire logic       reset_n,
	input wire logic       clk_en,
	input wire logic       sclk,
	input wire logic       chip_sel_n,
	input wire logic       miso,
	input wire logic       miso_oe,
	input wire logic       motion_valid,
	input wire logic       irq_edge_mode,
	input wire logic       irq_active_high,
	input wire logic       movement_irq,
	input wire logic [3:0] power_tier,
	input wire logic       move_flag
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n || !clk_en);
	logic [15:0] hi_q;
	logic [3:0]  age_q;
	logic        sclk_q;
	wire  logic  sclk_fall;
	// Raw pin fall; the design sees it a few cycles later, hence the age bound below.
	assign sclk_fall = sclk_q & ~sclk;
	// Length of the current interrupt high phase and cycles since the last clock fall.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hi_q <= '0;
			age_q <= 4'hF;
			sclk_q <= 1'b1;
		end else begin
			hi_q <= movement_irq ? hi_q + 16'h1 : '0;
			age_q <= sclk_fall ? '0 : age_q + {3'h0, age_q != 4'hF};
			sclk_q <= sclk;
		end
	end
	property p_idle_release;
		chip_sel_n [*3] |-> !miso_oe;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("miso driven while deselected");
	property p_sel_active;
		!chip_sel_n [*4] |-> miso_oe;
	endproperty
	a_sel_active: assert property (p_sel_active) else $error("port not active after select");
	property p_abort_clear;
		chip_sel_n [*4] |-> !miso;
	endproperty
	a_abort_clear: assert property (p_abort_clear) else $error("miso not cleared on deselect");
	property p_tier_order;
		power_tier != $past(power_tier) |->
			power_tier == TIER_RUN || power_tier == ($past(power_tier) << 1);
	endproperty
	a_tier_order: assert property (p_tier_order) else $error("tier step out of order");
	property p_level;
		!irq_edge_mode && irq_active_high && $past(!irq_edge_mode && irq_active_high) |->
			movement_irq == $past(move_flag);
	endproperty
	a_level: assert property (p_level) else $error("level interrupt off move flag");
	property p_edge_wake;
		$rose(movement_irq) && irq_edge_mode && irq_active_high |->
			power_tier == TIER_RUN && move_flag;
	endproperty
	a_edge_wake: assert property (p_edge_wake) else $error("edge pulse without wake");
	property p_pulse_len;
		$fell(movement_irq) && irq_edge_mode && irq_active_high |->
			hi_q == 16'(IRQ_PULSE_CYC);
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("edge pulse width wrong");
	property p_run_flag;
		motion_valid && power_tier == TIER_RUN |=> move_flag;
	endproperty
	a_run_flag: assert property (p_run_flag) else $error("move flag not set");
	property p_clear_cause;
		$fell(move_flag) |-> !$past(motion_valid);
	endproperty
	a_clear_cause: assert property (p_clear_cause) else $error("flag cleared over motion");
	property p_miso_fall;
		miso_oe && $changed(miso) |-> age_q <= 4'h6;
	endproperty
	a_miso_fall: assert property (p_miso_fall) else $error("miso changed off clock fall");
endmodule

bind ossp_serial_port ossp_checker #(.TICK_LEN(TICK_LEN)) u_chk (
	.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .sclk(sclk),
	.chip_sel_n(chip_sel_n), .miso(miso), .miso_oe(miso_oe), .motion_valid(motion_valid),
	.irq_edge_mode(irq_edge_mode), .irq_active_high(irq_active_high),
	.movement_irq(movement_irq), .power_tier(power_tier), .move_flag(move_flag));

/* tb/ossp_host.sv */
// Host master model of the serial port: mode 3, MSB first, 125 ns clock period.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module ossp_host (
	output logic      sclk,
	output logic      mosi,
	output logic      chip_sel_n,
	input  wire logic mclk,
	input  wire logic miso
);
	// Only this model starts transfers; the clock stands high outside frames.
	initial begin
		sclk = 1'b1;
		mosi = 1'b0;
		chip_sel_n = 1'b1;
	end
	// Shifts nb bits out; mosi is inverted afterwards so a late sample shows up.
	task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		rx = '0;
		for (int i = 7; i > 7 - nb; i--) begin
			sclk = 1'b0;
			mosi = tx[i];
			#62.5;
			sclk = 1'b1;
			rx[i] = miso;
			#62.5;
		end
		mosi = ~mosi;
	endtask
	// Frames start just off a core clock fall, so no serial edge lands on a rising core edge.
	task automatic sel();
		@(negedge mclk);
		chip_sel_n = 1'b0;
		#201;
	endtask
	task automatic desel();
		#200;
		chip_sel_n = 1'b1;
		#500;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		sel();
		xfer({1'b1, a}, 8, r);
		xfer(d, 8, r);
		desel();
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		logic [7:0] r;
		sel();
		xfer({1'b0, a}, 8, r);
		#4000;
		xfer(8'h00, 8, d);
		desel();
	endtask
endmodule

/* tb/testbench.sv */
// Bench of the serial port: registers, motion report, burst, tiers and interrupt.
// Assumes the host model and the bound checker; the tick is cut to four cycles.
`timescale 1ns/1ps
module testbench;
	import ossp_pkg::*;
	localparam int TL = 4;
	logic            mclk = 1'b0;
	logic            reset_n = 1'b0;
	logic            mv = 1'b0;
	logic [11:0]     dx = '0;
	logic [11:0]     dy = '0;
	logic            r12 = 1'b0;
	logic            edg = 1'b0;
	logic            ahi = 1'b1;
	wire logic       sclk, mosi, csn, miso, oe, irq, flag, miso_w;
	wire logic [3:0] tier;
	logic [7:0]      rv;
	int              n;
	int              n_fail = 0;
	int              cmp_count = 0;
	always #5 mclk = ~mclk;
	// A released miso line toggles so a stale value is never read as data.
	assign miso_w = oe ? miso : mclk;
	ossp_serial_port #(.TICK_LEN(TL)) u_dut (
		.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .sclk(sclk), .mosi(mosi),
		.chip_sel_n(csn), .miso(miso), .miso_oe(oe), .motion_valid(mv), .motion_dx(dx),
		.motion_dy(dy), .report_12bit(r12), .irq_edge_mode(edg), .irq_active_high(ahi),
		.movement_irq(irq), .power_tier(tier), .move_flag(flag));
	ossp_host u_host (.sclk(sclk), .mosi(mosi), .chip_sel_n(csn), .mclk(mclk), .miso(miso_w));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic move(input logic [11:0] x, input logic [11:0] y);
		@(negedge mclk);
		mv = 1'b1;
		dx = x;
		dy = y;
		@(negedge mclk);
		mv = 1'b0;
	endtask
	// Waits for a tier and returns the cycles spent; a timeout ends the run.
	task automatic wait_for(input logic [3:0] t, input int lim, output int c);
		c = 0;
		while (tier !== t && c < lim) begin
			@(negedge mclk);
			c++;
		end
		if (tier !== t) begin
			chk("tier wait", t, tier);
			close_out();
		end
	endtask
	task automatic t_regs();
		for (int i = 0; i < CFG_COUNT; i++) begin
			u_host.rd(ADDR_CFG_FIRST + 7'(i), rv);
			chk("cfg reset", CFG_RESET[i], rv);
		end
		u_host.wr(ADDR_CFG_FIRST, 8'hFF);
		u_host.rd(ADDR_CFG_FIRST, rv);
		chk("cfg write", 8'hFF, rv);
		u_host.xfer({1'b1, ADDR_CFG_FIRST}, 8, rv);
		u_host.xfer(8'h3C, 8, rv);
		u_host.sel();
		u_host.xfer({1'b1, ADDR_CFG_FIRST}, 8, rv);
		u_host.xfer(8'h3C, 5, rv);
		u_host.desel();
		u_host.rd(ADDR_CFG_FIRST, rv);
		chk("cfg kept", 8'hFF, rv);
		u_host.rd(7'h20, rv);
		chk("unmapped", 8'h00, rv);
	endtask
	task automatic t_motion();
		move(12'h123, 12'hF85);
		wait_for(TIER_RUN, 2000, n);
		move(12'h001, 12'h002);
		@(negedge mclk);
		chk("irq level", 8'h01, {7'h0, irq});
		ahi = 1'b0;
		repeat (2) @(negedge mclk);
		chk("irq low", 8'h00, {7'h0, irq});
		ahi = 1'b1;
		u_host.rd(ADDR_MOVE_STAT, rv);
		chk("flag bit", 8'h01, {7'h0, rv[MOVE_FLAG_BIT]});
		u_host.rd(ADDR_DISP_X, rv);
		chk("x low", 8'h24, rv);
		u_host.rd(ADDR_DISP_Y, rv);
		chk("y low", 8'h87, rv);
		chk("irq off", 8'h00, {6'h0, irq, flag});
		u_host.rd(ADDR_DISP_X, rv);
		chk("x zeroed", 8'h00, rv);
		@(negedge mclk);
		r12 = 1'b1;
		move(12'h5A1, 12'h3B2);
		u_host.rd(ADDR_DISP_X, rv);
		chk("x12 low", 8'hA1, rv);
		u_host.rd(ADDR_DISP_Y, rv);
		chk("y12 low", 8'hB2, rv);
		chk("flag held", 8'h01, {7'h0, flag});
		u_host.rd(ADDR_DISP_UPPER, rv);
		chk("upper", 8'h53, rv);
		chk("flag done", 8'h00, {7'h0, flag});
	endtask
	task automatic t_burst();
		logic [7:0] eb [4] = '{8'hE4, 8'hC9, 8'h70, 8'h00};
		move(12'h7E4, 12'h0C9);
		u_host.sel();
		u_host.xfer({1'b0, ADDR_BURST}, 8, rv);
		#4000;
		for (int i = 0; i < 4; i++) begin
			u_host.xfer(8'h00, 8, rv);
			chk("burst", eb[i], rv);
		end
		u_host.xfer({1'b1, ADDR_CFG_FIRST}, 8, rv);
		u_host.xfer(8'h11, 8, rv);
		u_host.desel();
		u_host.rd(ADDR_CFG_FIRST, rv);
		chk("burst lock", 8'hFF, rv);
		chk("burst clr", 8'h00, {7'h0, flag});
	endtask
	task automatic t_tiers();
		int e0;
		int e1;
		int e2;
		e0 = int'(DWELL_UNIT_RUN) * TL;
		e1 = int'(DWELL_UNIT_T1) * int'(CFG_RESET[CFG_T1_DWELL]) * TL;
		e2 = int'(DWELL_UNIT_T2) * TL;
		@(negedge mclk);
		edg = 1'b1;
		u_host.wr(ADDR_CFG_FIRST, 8'h01);
		u_host.wr(ADDR_CFG_FIRST + 7'h4, 8'h01);
		// The shortened run dwell may already have expired, so a motion restarts it cleanly.
		move(12'h001, 12'h000);
		wait_for(TIER_RUN, 100, n);
		wait_for(TIER_1, 20000, n);
		chk("run dwell", 8'h01, {7'h0, n >= e0 - 2 * TL && n <= e0 + 2 * TL});
		wait_for(TIER_2, e1 + 100, n);
		chk("t1 dwell", 8'h01, {7'h0, n >= e1 - 2 * TL && n <= e1 + 2 * TL});
		wait_for(TIER_3, e2 + 100, n);
		chk("t2 dwell", 8'h01, {7'h0, n >= e2 - 2 * TL && n <= e2 + 2 * TL});
		move(12'h010, 12'h000);
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(negedge mclk);
			n++;
		end
		chk("wake time", 8'h01, {7'h0, n <= (int'(CFG_RESET[CFG_T3_PERIOD]) + 3) * TL});
		chk("wake tier", TIER_RUN, tier);
		n = 0;
		while (irq === 1'b1 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		chk("pulse", {2'h0, IRQ_PULSE_CYC}, 8'(n));
	endtask
	// Main sequence: hold reset, check idle pins, then run every scenario.
	initial begin
		repeat (12) @(negedge mclk);
		reset_n = 1'b1;
		repeat (4) @(negedge mclk);
		chk("reset tier", TIER_RUN, tier);
		chk("reset pins", 8'h00, {6'h0, oe, flag});
		t_regs();
		t_motion();
		t_burst();
		t_tiers();
		close_out();
	end
endmodule
